// ===== hw/drive_cfg_pkg.sv
// Register map, field positions and reset values for the drive config bank.
// Assumes an 8-bit register path with a 7-bit register address.
package drive_cfg_pkg;
  localparam logic [6:0] drive_supply_control_off       = 7'h16;
  localparam logic [6:0] echo_threshold_config_off      = 7'h17;
  localparam logic [6:0] crossing_comparator_config_off = 7'h18;
  localparam logic [6:0] primary_current_limit_off      = 7'h19;
  localparam logic [6:0] pulse_burst_config_off         = 7'h1A;
  localparam logic [6:0] operating_mode_control_off     = 7'h1B;

  localparam logic [7:0] drive_supply_control_rst       = 8'h20;
  localparam logic [7:0] echo_threshold_config_rst      = 8'h07;
  localparam logic [7:0] crossing_comparator_config_rst = 8'h14;
  localparam logic [7:0] primary_current_limit_rst      = 8'h00;
  localparam logic [7:0] pulse_burst_config_rst         = 8'h00;
  localparam logic [7:0] operating_mode_control_rst     = 8'h00;

  // Writable bit masks; zero bits are reserved
  localparam logic [7:0] drive_supply_control_mask       = 8'h7F;
  localparam logic [7:0] echo_threshold_config_mask      = 8'h1F;
  localparam logic [7:0] crossing_comparator_config_mask = 8'hFF;
  localparam logic [7:0] primary_current_limit_mask      = 8'h3F;
  localparam logic [7:0] pulse_burst_config_mask         = 8'hBF;
  localparam logic [7:0] operating_mode_control_mask     = 8'hC3;

  // Field positions
  localparam int auto_charge_off_listen_bit = 6;
  localparam int drive_supply_float_bit     = 5;
  localparam int drive_supply_pullup_bit    = 4;
  localparam int echo_cmp_enable_bit        = 4;
  localparam int crossing_cmp_enable_bit    = 7;
  localparam int crossing_gate_bit          = 6;
  localparam int crossing_input_bit         = 5;
  localparam int inphase_drive_bit          = 7;
  localparam int sleep_request_bit          = 7;
  localparam int standby_request_bit        = 6;
  localparam int charge_gate_bit            = 1;
  localparam int burst_command_bit          = 0;

  localparam logic [1:0] pin_scheme_cmd = 2'h0;

  // Burst phase of the drive sequencer
  typedef enum logic [1:0] {
    burst_idle  = 2'b00,
    burst_run   = 2'b01,
    burst_done  = 2'b10
  } burst_state_type;
endpackage

// ===== hw/pulse_counter.sv
// Counts drive pulses of one burst against a programmed limit.
// Assumes pulse_tick is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/1ps
module pulse_counter #(
  parameter int width = 6
) (
  input  wire logic             sys_clk,    // System clock
  input  wire logic             resetn,     // Async reset, low
  input  wire logic             clear,      // Restart count
  input  wire logic             pulse_tick, // One drive pulse
  input  wire logic [width-1:0] limit,      // Zero means no limit
  output logic                  reached     // Limit met
);
  logic [width-1:0] count_q;
  logic [width-1:0] count_d;

  // Next count; a zero limit never ends the burst
  always_comb
  begin
    count_d = count_q;
    if (clear)
      count_d = '0;
    else if (pulse_tick && !reached)
      count_d = count_q + width'(1);
  end

  assign reached = (limit != '0) && (count_q >= limit);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      count_q <= '0;
    else
      count_q <= count_d;
  end
endmodule

// ===== hw/ultrasonic_drive_config_regs.sv
// Register bank 0x16..0x1B for the transducer drive front end, and the
// control outputs it steers. Assumes a serial slave front end that
// hands in one-cycle write and read strobes with address and data,
// synchronous to sys_clk; low-voltage control pins arrive raw.
`timescale 1ns/1ps
module ultrasonic_drive_config_regs #(
  parameter int pulse_width = 6
) (
  input  wire logic       sys_clk,                 // 125 MHz clock
  input  wire logic       resetn,                  // Async reset, low
  input  wire logic       reg_wr,                  // Write strobe
  input  wire logic       reg_rd,                  // Read strobe
  input  wire logic [6:0] reg_addr,                // Register address
  input  wire logic [7:0] reg_wdata,               // Write data
  output logic [7:0]      reg_rdata,               // Read data
  input  wire logic       output_span_sel,         // Span from other bank
  input  wire logic [1:0] pin_scheme,              // Pin scheme select
  input  wire logic       pulse_pin,               // Raw drive pulse pin
  input  wire logic       echo_detect_raw,         // Raw echo comparator
  input  wire logic       crossing_raw,            // Raw zero-cross comparator
  output logic            supply_float,            // Source off, no reg
  output logic            supply_charge_en,        // Charging current on
  output logic            supply_pullup_sel,       // 0:10 mA 1:20 mA
  output logic [3:0]      supply_volt_code,        // Volts minus five
  output logic            echo_out_en,             // Echo output enable
  output logic            echo_out,                // Gated echo flag
  output logic [3:0]      echo_threshold_code,     // Threshold step
  output logic            threshold_span_sel,      // Threshold formula
  output logic            crossing_cmp_run,        // Comparator running
  output logic            crossing_out,            // Gated zero-cross
  output logic            crossing_input_select,   // 0:ref 1:neg input
  output logic [1:0]      crossing_stage_select,   // Source stage
  output logic [2:0]      crossing_hysteresis_code,// 30 mV + 50 mV*code
  output logic [5:0]      primary_current_clamp,   // 50 + 7.14 mA*code
  output logic            inphase_drive_mode,      // Half-bridge drive
  output logic            sleep_active,            // In sleep mode
  output logic            standby_active,          // In standby mode
  output logic            burst_active             // Burst running
);
  logic [7:0] supply_q, supply_d;
  logic [7:0] echo_q, echo_d;
  logic [7:0] cross_q, cross_d;
  logic [7:0] clamp_q, clamp_d;
  logic [7:0] burst_q, burst_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] rdata_d;
  logic [2:0] pulse_sync_q;
  logic [1:0] echo_sync_q;
  logic [1:0] cross_sync_q;
  logic       listen_off_q, listen_off_d;
  logic       burst_cmd;
  logic       pulse_tick;
  logic       count_reached;
  logic       burst_clear;
  drive_cfg_pkg::burst_state_type state_q, state_d;

  // Write merge that keeps reserved bits at zero
  function automatic logic [7:0] merge_write(input logic [6:0] off,
                                             input logic [7:0] mask,
                                             input logic [7:0] cur);
    logic hit;
    hit = reg_wr && (reg_addr == off);
    merge_write = hit ? (reg_wdata & mask) : cur;
  endfunction

  // Register write decode, serial path only
  always_comb
  begin
    supply_d = merge_write(drive_cfg_pkg::drive_supply_control_off,
                           drive_cfg_pkg::drive_supply_control_mask,
                           supply_q);
    echo_d   = merge_write(drive_cfg_pkg::echo_threshold_config_off,
                           drive_cfg_pkg::echo_threshold_config_mask,
                           echo_q);
    cross_d  = merge_write(drive_cfg_pkg::crossing_comparator_config_off,
                           drive_cfg_pkg::crossing_comparator_config_mask,
                           cross_q);
    clamp_d  = merge_write(drive_cfg_pkg::primary_current_limit_off,
                           drive_cfg_pkg::primary_current_limit_mask,
                           clamp_q);
    burst_d  = merge_write(drive_cfg_pkg::pulse_burst_config_off,
                           drive_cfg_pkg::pulse_burst_config_mask,
                           burst_q);
    mode_d   = merge_write(drive_cfg_pkg::operating_mode_control_off,
                           drive_cfg_pkg::operating_mode_control_mask,
                           mode_q);
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = reg_rdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        drive_cfg_pkg::drive_supply_control_off:       rdata_d = supply_q;
        drive_cfg_pkg::echo_threshold_config_off:      rdata_d = echo_q;
        drive_cfg_pkg::crossing_comparator_config_off: rdata_d = cross_q;
        drive_cfg_pkg::primary_current_limit_off:      rdata_d = clamp_q;
        drive_cfg_pkg::pulse_burst_config_off:         rdata_d = burst_q;
        drive_cfg_pkg::operating_mode_control_off:     rdata_d = mode_q;
        default:                                       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      supply_q  <= drive_cfg_pkg::drive_supply_control_rst;
      echo_q    <= drive_cfg_pkg::echo_threshold_config_rst;
      cross_q   <= drive_cfg_pkg::crossing_comparator_config_rst;
      clamp_q   <= drive_cfg_pkg::primary_current_limit_rst;
      burst_q   <= drive_cfg_pkg::pulse_burst_config_rst;
      mode_q    <= drive_cfg_pkg::operating_mode_control_rst;
      reg_rdata <= 8'h00;
    end
    else
    begin
      supply_q  <= supply_d;
      echo_q    <= echo_d;
      cross_q   <= cross_d;
      clamp_q   <= clamp_d;
      burst_q   <= burst_d;
      mode_q    <= mode_d;
      reg_rdata <= rdata_d;
    end
  end

  // Two-flop synchronisers for pin inputs; the pulse pin has a third flop for edge detect
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pulse_sync_q <= 3'h0;
      echo_sync_q  <= 2'h0;
      cross_sync_q <= 2'h0;
    end
    else
    begin
      pulse_sync_q <= {pulse_sync_q[1:0], pulse_pin};
      echo_sync_q  <= {echo_sync_q[0], echo_detect_raw};
      cross_sync_q <= {cross_sync_q[0], crossing_raw};
    end
  end

  // Rising edge of synchronised pulse pin
  assign pulse_tick = pulse_sync_q[1] && !pulse_sync_q[2];

  // Burst command honoured only in scheme zero
  // scheme gate
  assign burst_cmd = (pin_scheme == drive_cfg_pkg::pin_scheme_cmd)
                     && mode_q[drive_cfg_pkg::burst_command_bit]
                     && !mode_q[drive_cfg_pkg::sleep_request_bit];
  assign burst_clear = (state_q == drive_cfg_pkg::burst_idle);

  // Pulse count limit, zero for continuous
  // burst length
  pulse_counter #(
    .width (pulse_width)
  ) u_pulse_counter (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .clear      (burst_clear),
    .pulse_tick (pulse_tick && (state_q == drive_cfg_pkg::burst_run)),
    .limit      (burst_q[pulse_width-1:0]),
    .reached    (count_reached)
  );

  // Burst sequencer and listen-mode charge cutoff
  always_comb
  begin
    state_d      = state_q;
    listen_off_d = listen_off_q;
    unique case (state_q)
      drive_cfg_pkg::burst_idle:
        if (burst_cmd)
        begin
          state_d      = drive_cfg_pkg::burst_run;
          listen_off_d = 1'b0;
        end
      drive_cfg_pkg::burst_run:
        if (!burst_cmd || count_reached)
        begin
          state_d = drive_cfg_pkg::burst_done;
          listen_off_d = 1'b1;
        end
      drive_cfg_pkg::burst_done:
        if (!burst_cmd)
          state_d = drive_cfg_pkg::burst_idle;
      default:
        state_d = drive_cfg_pkg::burst_idle;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q      <= drive_cfg_pkg::burst_idle;
      listen_off_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      listen_off_q <= listen_off_d;
    end
  end

  // Registered control outputs
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      supply_float             <= drive_cfg_pkg::drive_supply_control_rst[5];
      supply_charge_en         <= 1'b0;
      supply_pullup_sel        <= 1'b0;
      supply_volt_code         <= 4'h0;
      echo_out_en              <= 1'b0;
      echo_out                 <= 1'b0;
      echo_threshold_code      <=
        drive_cfg_pkg::echo_threshold_config_rst[3:0];
      threshold_span_sel       <= 1'b0;
      crossing_cmp_run         <= 1'b0;
      crossing_out             <= 1'b0;
      crossing_input_select    <= 1'b0;
      crossing_stage_select    <=
        drive_cfg_pkg::crossing_comparator_config_rst[4:3];
      crossing_hysteresis_code <=
        drive_cfg_pkg::crossing_comparator_config_rst[2:0];
      primary_current_clamp    <= 6'h00;
      inphase_drive_mode       <= 1'b0;
      sleep_active             <= 1'b0;
      standby_active           <= 1'b0;
      burst_active             <= 1'b0;
    end
    else
    begin
      supply_float <= supply_q[drive_cfg_pkg::drive_supply_float_bit];
      supply_charge_en <=
        !supply_q[drive_cfg_pkg::drive_supply_float_bit]
        && (!supply_q[drive_cfg_pkg::auto_charge_off_listen_bit]
            || mode_q[drive_cfg_pkg::charge_gate_bit]
            || !listen_off_q);
      supply_pullup_sel <= supply_q[drive_cfg_pkg::drive_supply_pullup_bit];
      supply_volt_code <= supply_q[3:0];
      echo_out_en <= echo_q[drive_cfg_pkg::echo_cmp_enable_bit];
      echo_out    <= echo_q[drive_cfg_pkg::echo_cmp_enable_bit]
                     && echo_sync_q[1];
      echo_threshold_code <= echo_q[3:0];
      threshold_span_sel <= output_span_sel;
      crossing_cmp_run <= cross_q[drive_cfg_pkg::crossing_cmp_enable_bit];
      crossing_out <= cross_q[drive_cfg_pkg::crossing_cmp_enable_bit]
                      && cross_sync_q[1]
                      && (!cross_q[drive_cfg_pkg::crossing_gate_bit]
                          || echo_sync_q[1]);
      crossing_input_select <= cross_q[drive_cfg_pkg::crossing_input_bit];
      crossing_stage_select <= cross_q[4:3];
      crossing_hysteresis_code <= cross_q[2:0];
      primary_current_clamp <= clamp_q[5:0];
      inphase_drive_mode <= burst_q[drive_cfg_pkg::inphase_drive_bit];
      sleep_active <= mode_q[drive_cfg_pkg::sleep_request_bit];
      standby_active <= mode_q[drive_cfg_pkg::standby_request_bit];
      burst_active <= (state_d == drive_cfg_pkg::burst_run);
    end
  end
endmodule

// ===== tb/reg_host_model.sv
// Host-side model that turns access requests into bank strobes.
// Assumes requests arrive as a one-cycle go pulse on sys_clk.
`timescale 1ns/1ps
module reg_host_model (
  input  wire logic       sys_clk,   // Clock
  input  wire logic       resetn,    // Reset, low
  input  wire logic       go,        // Start access
  input  wire logic       go_wr,     // 1 write, 0 read
  input  wire logic [6:0] go_addr,   // Register address
  input  wire logic [7:0] go_data,   // Write value
  input  wire logic [7:0] reg_rdata, // Bank read data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  output logic [6:0]      reg_addr,  // Address lines
  output logic [7:0]      reg_wdata, // Data lines
  output logic [7:0]      rd_value,  // Captured read
  output logic            done       // Access over
);
  logic rd_wait;
  // sole register path
  // One strobe per request; idle lines toggle so stale values never match
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {reg_wr, reg_rd, rd_wait, done} <= '0;
      reg_addr <= '0;
      reg_wdata <= '0;
      rd_value <= '0;
    end
    else
    begin
      reg_wr <= go && go_wr;
      reg_rd <= go && !go_wr;
      reg_addr <= go ? go_addr : ~reg_addr;
      reg_wdata <= go ? go_data : ~reg_wdata;
      rd_wait <= reg_rd;
      done <= rd_wait || reg_wr;
      if (rd_wait)
        rd_value <= reg_rdata;
    end
  end
endmodule

// ===== tb/drive_cfg_properties.sv
// Concurrent checks on the drive config bank ports.
// Assumes binding to ultrasonic_drive_config_regs, one clock domain.
`timescale 1ns/1ps
module drive_cfg_properties (
  input wire logic       sys_clk,               // Clock
  input wire logic       resetn,                // Reset, low
  input wire logic       reg_wr,                // Write strobe
  input wire logic       reg_rd,                // Read strobe
  input wire logic [6:0] reg_addr,              // Address
  input wire logic [7:0] reg_wdata,             // Write data
  input wire logic [7:0] reg_rdata,             // Read data
  input wire logic       output_span_sel,       // Span in
  input wire logic [1:0] pin_scheme,            // Scheme in
  input wire logic       echo_detect_raw,       // Raw echo pin
  input wire logic       crossing_raw,          // Raw crossing pin
  input wire logic       supply_float,          // Float
  input wire logic       supply_charge_en,      // Charging
  input wire logic       supply_pullup_sel,     // Pull-up
  input wire logic [3:0] supply_volt_code,      // Volts
  input wire logic       echo_out_en,           // Echo enable
  input wire logic       echo_out,              // Echo flag
  input wire logic       threshold_span_sel,    // Span out
  input wire logic       crossing_cmp_run,      // Crossing run
  input wire logic       crossing_out,          // Crossing out
  input wire logic [5:0] primary_current_clamp, // Clamp
  input wire logic       inphase_drive_mode,    // In-phase
  input wire logic       sleep_active,          // Sleep
  input wire logic       burst_active           // Burst
);
  // Write decodes for registers 0x16, 0x19, 0x1A and 0x1B
  wire w16 = reg_wr && reg_addr == 7'h16;
  wire w19 = reg_wr && reg_addr == 7'h19;
  wire w1a = reg_wr && reg_addr == 7'h1A;
  wire w1b = reg_wr && reg_addr == 7'h1B;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_float;
    w16 ##1 !w16 |=> supply_float == $past(reg_wdata[5], 2);
  endproperty
  property p_pullup;
    w16 ##1 !w16 |=> supply_pullup_sel == $past(reg_wdata[4], 2);
  endproperty
  property p_volt;
    w16 ##1 !w16 |=> supply_volt_code == $past(reg_wdata[3:0], 2);
  endproperty
  property p_clamp;
    w19 ##1 !w19 |=> primary_current_clamp == $past(reg_wdata[5:0], 2);
  endproperty
  property p_inph;
    w1a ##1 !w1a |=> inphase_drive_mode == $past(reg_wdata[7], 2);
  endproperty
  property p_sleep;
    w1b ##1 !w1b |=> sleep_active == $past(reg_wdata[7], 2);
  endproperty
  property p_echo;
    echo_out == (echo_out_en && $past(echo_detect_raw, 3));
  endproperty
  property p_cross;
    crossing_out |-> crossing_cmp_run && $past(crossing_raw, 3);
  endproperty
  property p_charge;
    supply_float |-> !supply_charge_en;
  endproperty
  property p_scheme;
    $rose(burst_active) |-> $past(pin_scheme) == 2'h0;
  endproperty
  property p_span;
    $past(resetn) |-> threshold_span_sel == $past(output_span_sel);
  endproperty
  property p_rsv;
    reg_rd && reg_addr == 7'h1B |=> reg_rdata[5:2] == 4'h0;
  endproperty
  a_float: assert property (p_float)
    else $error("float bit not applied");
  a_pullup: assert property (p_pullup)
    else $error("pull-up select not applied");
  a_volt: assert property (p_volt)
    else $error("voltage code not applied");
  a_clamp: assert property (p_clamp)
    else $error("clamp code not applied");
  a_inph: assert property (p_inph)
    else $error("in-phase mode not applied");
  a_sleep: assert property (p_sleep)
    else $error("sleep bit not applied");
  a_echo: assert property (p_echo)
    else $error("echo flag while disabled");
  a_cross: assert property (p_cross)
    else $error("crossing output while stopped");
  a_charge: assert property (p_charge)
    else $error("charging while floating");
  a_scheme: assert property (p_scheme)
    else $error("burst outside scheme zero");
  a_span: assert property (p_span)
    else $error("span select not followed");
  a_rsv: assert property (p_rsv)
    else $error("reserved mode bits not zero");
  c_burst: cover property ($rose(burst_active));
  c_cross: cover property (crossing_out);
  c_echo: cover property (echo_out);
endmodule

// ===== tb/test_ultrasonic_drive_config_regs.sv
// Self-checking bench for the drive config register bank.
// Assumes reg_host_model as bus partner and the checker bound below.
`timescale 1ns/1ps
module test_ultrasonic_drive_config_regs;
  logic sys_clk, resetn, go, go_wr, done, reg_wr, reg_rd, output_span_sel;
  logic pulse_pin, echo_detect_raw, crossing_raw, supply_float, echo_out;
  logic supply_charge_en, supply_pullup_sel, echo_out_en, threshold_span_sel;
  logic crossing_cmp_run, crossing_out, crossing_input_select, burst_active;
  logic inphase_drive_mode, sleep_active, standby_active;
  logic [1:0] pin_scheme, crossing_stage_select;
  logic [2:0] crossing_hysteresis_code;
  logic [3:0] supply_volt_code, echo_threshold_code;
  logic [5:0] primary_current_clamp;
  logic [6:0] go_addr, reg_addr;
  logic [7:0] go_data, reg_wdata, reg_rdata, rd_value, v;
  int err_count = 0, cmp_count = 0, cyc = 0, n, i;
  logic [7:0] rst_v [6] = '{8'h20, 8'h07, 8'h14, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [6] = '{8'h7F, 8'h1F, 8'hFF, 8'h3F, 8'hBF, 8'hC3};
  logic [7:0] vis [6] = '{8'h3F, 8'h1F, 8'hBF, 8'h3F, 8'h80, 8'hC0};
  ultrasonic_drive_config_regs ultrasonic_drive_config_regs_inst (
    .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .output_span_sel(output_span_sel), .pin_scheme(pin_scheme),
    .pulse_pin(pulse_pin), .echo_detect_raw(echo_detect_raw),
    .crossing_raw(crossing_raw), .supply_float(supply_float),
    .supply_charge_en(supply_charge_en),
    .supply_pullup_sel(supply_pullup_sel),
    .supply_volt_code(supply_volt_code), .echo_out_en(echo_out_en),
    .echo_out(echo_out), .echo_threshold_code(echo_threshold_code),
    .threshold_span_sel(threshold_span_sel),
    .crossing_cmp_run(crossing_cmp_run), .crossing_out(crossing_out),
    .crossing_input_select(crossing_input_select),
    .crossing_stage_select(crossing_stage_select),
    .crossing_hysteresis_code(crossing_hysteresis_code),
    .primary_current_clamp(primary_current_clamp),
    .inphase_drive_mode(inphase_drive_mode), .sleep_active(sleep_active),
    .standby_active(standby_active), .burst_active(burst_active)
  );
  reg_host_model reg_host_model_inst (
    .sys_clk(sys_clk), .resetn(resetn), .go(go), .go_wr(go_wr),
    .go_addr(go_addr), .go_data(go_data), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .rd_value(rd_value), .done(done)
  );
  // Outputs steered by register i, in register bit layout
  function automatic logic [7:0] outs(int k);
    case (k)
      0: return {2'b00, supply_float, supply_pullup_sel, supply_volt_code};
      1: return {3'b000, echo_out_en, echo_threshold_code};
      2: return {crossing_cmp_run, 1'b0, crossing_input_select,
                 crossing_stage_select, crossing_hysteresis_code};
      3: return {2'b00, primary_current_clamp};
      4: return {inphase_drive_mode, 7'h00};
      default: return {sleep_active, standby_active, 6'h00};
    endcase
  endfunction
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One register access through the host model
  task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
    @(posedge sys_clk);
    go <= 1'b1;
    go_wr <= w;
    go_addr <= a;
    go_data <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    do @(negedge sys_clk); while (done !== 1'b1 && ++n < 8);
    check("access done", {7'h00, done}, 8'h01);
  endtask
  task automatic ticks(int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic pulses(int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      pulse_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pulse_pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    ticks(8);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Clock and cycle ceiling
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    {resetn, go, go_wr, go_addr, go_data, output_span_sel} = '0;
    {pin_scheme, pulse_pin, echo_detect_raw, crossing_raw} = '0;
    void'($urandom(73922));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      acc(1'b0, 7'(8'h16 + k), 8'h00);
      check("reset value", rd_value, rst_v[k]);
      check("reset outputs", outs(k), rst_v[k] & vis[k]);
    end
    acc(1'b1, 7'h1C, 8'hFF);
    acc(1'b0, 7'h1C, 8'h00);
    check("unmapped read", rd_value, 8'h00);
    // Random writes, read back and output mapping
    repeat (30)
    begin
      i = $urandom % 6;
      v = 8'($urandom) & (i == 5 ? 8'hFE : 8'hFF);
      acc(1'b1, 7'(8'h16 + i), v);
      acc(1'b0, 7'(8'h16 + i), 8'h00);
      check("read back", rd_value, v & msk[i]);
      check("steered outputs", outs(i), v & msk[i] & vis[i]);
      @(posedge sys_clk);
      output_span_sel <= 1'($urandom);
    end
    // Echo flag and crossing gating
    @(posedge sys_clk);
    crossing_raw <= 1'b1;
    acc(1'b1, 7'h18, 8'hC0);
    ticks(6);
    check("gated crossing", crossing_out, 8'h00);
    acc(1'b1, 7'h18, 8'h80);
    ticks(3);
    check("free crossing", crossing_out, 8'h01);
    acc(1'b1, 7'h17, 8'h07);
    acc(1'b1, 7'h18, 8'hC0);
    @(posedge sys_clk);
    echo_detect_raw <= 1'b1;
    ticks(6);
    check("echo off", echo_out, 8'h00);
    check("detect crossing", crossing_out, 8'h01);
    acc(1'b1, 7'h17, 8'h17);
    ticks(3);
    check("echo on", echo_out, 8'h01);
    // Counted burst, then charge-off in listen
    acc(1'b1, 7'h16, 8'h40);
    acc(1'b1, 7'h1A, 8'h03);
    acc(1'b1, 7'h1B, 8'h01);
    ticks(2);
    check("burst start", burst_active, 8'h01);
    check("charge in burst", supply_charge_en, 8'h01);
    pulses(2);
    check("burst midway", burst_active, 8'h01);
    pulses(1);
    check("burst end", burst_active, 8'h00);
    check("listen charge off", supply_charge_en, 8'h00);
    acc(1'b1, 7'h1B, 8'h03);
    ticks(2);
    check("gate charge on", supply_charge_en, 8'h01);
    acc(1'b1, 7'h16, 8'h60);
    ticks(2);
    check("float charge off", supply_charge_en, 8'h00);
    // Continuous burst ends only by command
    acc(1'b1, 7'h1B, 8'h00);
    acc(1'b1, 7'h1A, 8'h00);
    acc(1'b1, 7'h1B, 8'h01);
    pulses(66);
    check("continuous burst", burst_active, 8'h01);
    acc(1'b1, 7'h1B, 8'h00);
    ticks(2);
    check("burst stop", burst_active, 8'h00);
    // Command ignored outside scheme zero
    for (int s = 1; s < 4; s++)
    begin
      @(posedge sys_clk);
      pin_scheme <= 2'(s);
      acc(1'b1, 7'h1B, 8'h01);
      ticks(4);
      check("scheme burst", burst_active, 8'h00);
      acc(1'b1, 7'h1B, 8'h00);
    end
    close_out();
  end
endmodule
bind ultrasonic_drive_config_regs drive_cfg_properties
  drive_cfg_properties_inst (
  .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .output_span_sel(output_span_sel), .pin_scheme(pin_scheme),
  .echo_detect_raw(echo_detect_raw), .crossing_raw(crossing_raw),
  .supply_float(supply_float), .supply_charge_en(supply_charge_en),
  .supply_pullup_sel(supply_pullup_sel),
  .supply_volt_code(supply_volt_code), .echo_out_en(echo_out_en),
  .echo_out(echo_out), .threshold_span_sel(threshold_span_sel),
  .crossing_cmp_run(crossing_cmp_run), .crossing_out(crossing_out),
  .primary_current_clamp(primary_current_clamp),
  .inphase_drive_mode(inphase_drive_mode), .sleep_active(sleep_active),
  .burst_active(burst_active)
);
